// ==== src/ctu_defines.svh ====
// Purpose: Constants for the charge-time edge control block
// Assumes: 32-bit register port, word offsets in bytes
// Notes: Included by the design file, the property module and the bench; the package does not include it
`ifndef CTU_DEFINES_SVH
`define CTU_DEFINES_SVH

// ****************************************************
// Register offsets
// ****************************************************
`define CTU_ADDR_CTRL 8'h00
`define CTU_ADDR_STAT 8'h04
`define CTU_ADDR_MASK 8'h08

// ****************************************************
// Control register fields
// ****************************************************
`define CTU_B_EDGE1 24
`define CTU_B_E2MODE 23
`define CTU_B_E2POL 22
`define CTU_B_SRC_HI 21
`define CTU_B_SRC_LO 18
`define CTU_B_ON 15
`define CTU_B_IDLE 13
`define CTU_B_DELAY_GENERATION_ENABLE 12
`define CTU_B_EDGE_PASS_ENABLE 11
`define CTU_B_SEQ 10
`define CTU_B_GND 9
`define CTU_B_TRIG 8
`define CTU_CTRL_WMASK 32'h01FC_BF00
`define CTU_CTRL_RESET 32'h0000_0000

// ****************************************************
// Status / mask layout
// ****************************************************
`define CTU_S_EDGE1 0
`define CTU_S_EDGE2 1
`define CTU_S_NBITS 2

// ****************************************************
// Edge-two source codes
// ****************************************************
`define CTU_SRC_CMP3 4'hf
`define CTU_SRC_CMP2 4'he
`define CTU_SRC_CMP1 4'hd
`define CTU_SRC_PERIPHERAL_BUS_CLOCK 4'hc
`define CTU_SRC_CAP3 4'hb
`define CTU_SRC_CAP2 4'ha
`define CTU_SRC_CAP1 4'h9
`define CTU_SRC_EXT13 4'h8
`define CTU_SRC_EXT12 4'h7
`define CTU_SRC_EXT11 4'h6
`define CTU_SRC_EXT10 4'h5
`define CTU_SRC_EXT9 4'h4
`define CTU_SRC_EXT1 4'h3
`define CTU_SRC_EXT2 4'h2
`define CTU_SRC_CMPEV 4'h1
`define CTU_SRC_TMR1 4'h0

`endif

// ==== src/ctu_pkg.sv ====
// Purpose: Types for the charge-time edge control block
// Assumes: ctu_defines.svh on the include path
// Notes: Holds types only; numbers live in the header
package ctu_pkg;
   // Measurement phase of the unit
   typedef enum logic [1:0] {
      CTU_IDLE,
      CTU_ARMED,
      CTU_RUN,
      CTU_DONE
   } ctu_phase_e;
   // Edge-two source select code
   typedef logic [3:0] ctu_src_t;
endpackage

// ==== src/ctu_sync_edge.sv ====
// Purpose: Two-flop synchroniser with edge and level qualifier
// Assumes: Input may be asynchronous to clock_in
// Notes: First flop feeds only the second flop
module ctu_sync_edge (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic sig_in,
   input wire logic pos_in,
   input wire logic edge_mode_in,
   output logic hit_out
);
   logic meta_r; // First stage, read only by sync_r
   logic sync_r; // Second stage, safe to use
   logic prev_r; // Previous synced value for edge detection

   // Synchroniser chain
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= sig_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // Edge mode: chosen transition; level mode: chosen level held
   always_comb begin
      if (edge_mode_in) begin
         hit_out = pos_in ? (sync_r & ~prev_r) : (~sync_r & prev_r);
      end else begin
         hit_out = pos_in ? sync_r : ~sync_r;
      end
   end
endmodule

// ==== src/ctu_edge_ctrl.sv ====
// Purpose: Edge selection, qualification and recording for charge-time unit
// Assumes: Register port strobes are single cycle, read data one cycle later
// Notes: Edge one arrives on a dedicated input; edge two is chosen by code
//
// Notes on behaviour
// - Edge-one flag sets on edge, software writable
// - Edge-two sampling bit: edges or levels
// - Edge-two polarity bit: rising or falling
// - Codes 1111..1100 pick comparators and bus clock
// - Codes 1011..1001 pick capture events
// - Codes 1000..0010 pick external edge pins
// - Code 0001 compare event, 0000 timer
// - Enable bit turns the unit on
// - Idle-stop bit halts unit during idle
// - Delay-generation bit enables edge delay mode
// - Edge-pass bit blocks all edges when clear
// - Edge-order bit needs edge one first
// - Ground bit grounds the current source
// - Trigger bit enables trigger output
`include "ctu_defines.svh"

module ctu_edge_ctrl (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [31:0] reg_rdata_out,
   // Device state
   input wire logic idle_mode_in,
   // Edge sources
   input wire logic edge_one_in,
   input wire logic comparator_one_output_in,
   input wire logic comparator_two_output_in,
   input wire logic comparator_three_output_in,
   input wire logic peripheral_bus_clock_in,
   input wire logic capture_module_one_in,
   input wire logic capture_module_two_in,
   input wire logic capture_module_three_in,
   input wire logic [13:1] external_edge_pin_in,
   input wire logic compare_module_one_in,
   input wire logic first_timer_in,
   // Outputs toward the analog side, plus the interrupt
   output logic current_on_out,
   output logic current_source_ground_out,
   output logic trigger_out,
   output logic delay_pulse_out,
   output logic irq_out
);
   // ****************************************************
   // Register state
   // ****************************************************
   logic [31:0] ctrl_r; // Control word
   logic [`CTU_S_NBITS-1:0] stat_r; // Sticky event bits
   logic [`CTU_S_NBITS-1:0] mask_r; // Interrupt mask
   logic [31:0] rdata_r; // Read data register
   ctu_pkg::ctu_phase_e phase_r; // Measurement phase
   ctu_pkg::ctu_phase_e phase_nxt;

   // Every field is a plain slice of ctrl_r with nothing cached, so a
   // write reaches the qualifiers on the very next cycle
   // Field views of the control word
   logic edge_one_flag;
   logic edge_two_sampling;
   logic edge_two_polarity;
   ctu_pkg::ctu_src_t edge_two_source;
   logic unit_on;
   logic idle_stop;
   logic delay_generation_enable;
   logic edge_pass_enable;
   logic edge_order_enable;
   logic current_source_ground;
   logic trigger_output_enable;

   assign edge_one_flag = ctrl_r[`CTU_B_EDGE1];
   assign edge_two_sampling = ctrl_r[`CTU_B_E2MODE];
   assign edge_two_polarity = ctrl_r[`CTU_B_E2POL];
   assign edge_two_source = ctrl_r[`CTU_B_SRC_HI:`CTU_B_SRC_LO];
   assign unit_on = ctrl_r[`CTU_B_ON];
   assign idle_stop = ctrl_r[`CTU_B_IDLE];
   assign delay_generation_enable = ctrl_r[`CTU_B_DELAY_GENERATION_ENABLE];
   assign edge_pass_enable = ctrl_r[`CTU_B_EDGE_PASS_ENABLE];
   assign edge_order_enable = ctrl_r[`CTU_B_SEQ];
   assign current_source_ground = ctrl_r[`CTU_B_GND];
   assign trigger_output_enable = ctrl_r[`CTU_B_TRIG];

   // ****************************************************
   // Source selection
   // ****************************************************
   // External pins eight down to three have no code and are never picked
   // Mux function; used for the live selection only but kept as a
   // function so the code table sits in one readable place
   function automatic logic pick_src(input ctu_pkg::ctu_src_t code,
                                     input logic [13:1] ext,
                                     input logic c1, input logic c2,
                                     input logic c3, input logic pb,
                                     input logic i1, input logic i2,
                                     input logic i3, input logic oc,
                                     input logic t1);
      logic v;
      v = 1'b0;
      unique case (code)
         `CTU_SRC_CMP3: v = c3;
         `CTU_SRC_CMP2: v = c2;
         `CTU_SRC_CMP1: v = c1;
         `CTU_SRC_PERIPHERAL_BUS_CLOCK: v = pb;
         `CTU_SRC_CAP3: v = i3;
         `CTU_SRC_CAP2: v = i2;
         `CTU_SRC_CAP1: v = i1;
         `CTU_SRC_EXT13: v = ext[13];
         `CTU_SRC_EXT12: v = ext[12];
         `CTU_SRC_EXT11: v = ext[11];
         `CTU_SRC_EXT10: v = ext[10];
         `CTU_SRC_EXT9: v = ext[9];
         `CTU_SRC_EXT1: v = ext[1];
         `CTU_SRC_EXT2: v = ext[2];
         `CTU_SRC_CMPEV: v = oc;
         `CTU_SRC_TMR1: v = t1;
      endcase
      return v;
   endfunction

   // The selector runs ahead of the synchroniser; a code change while the
   // unit is live can look like an edge for up to three cycles, so
   // software should change the code only while the unit is off
   logic edge_two_raw; // Selected, unsynchronised source
   assign edge_two_raw = pick_src(edge_two_source, external_edge_pin_in,
      comparator_one_output_in, comparator_two_output_in,
      comparator_three_output_in, peripheral_bus_clock_in,
      capture_module_one_in, capture_module_two_in, capture_module_three_in,
      compare_module_one_in, first_timer_in);

   // ****************************************************
   // Synchronise and qualify
   // ****************************************************
   // Hits last one cycle in edge mode and stay up in level mode
   logic edge_one_hit; // Rising edge one after sync
   logic edge_two_hit; // Qualified edge two after sync

   // Both paths use the same synchroniser, so edge one and edge two see
   // the same latency and the measured span is not skewed
   // Edge one is always a rising-edge event
   ctu_sync_edge u_sync_one (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .sig_in(edge_one_in),
      .pos_in(1'b1),
      .edge_mode_in(1'b1),
      .hit_out(edge_one_hit)
   );

   // Bus-clock source aliases against clock_in; it gives a beat pattern,
   // which is why it is only useful as a coarse reference
   ctu_sync_edge u_sync_two (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .sig_in(edge_two_raw),
      .pos_in(edge_two_polarity),
      .edge_mode_in(edge_two_sampling),
      .hit_out(edge_two_hit)
   );

   // ****************************************************
   // Qualification
   // ****************************************************
   // Unit is live when on and not halted by idle
   logic active;
   assign active = unit_on & ~(idle_stop & idle_mode_in);

   // Blocking sits after the synchroniser, so in edge mode a source that
   // moved while blocked leaves no stale edge once edges pass again
   logic e1_ok; // Edge one may act
   logic e2_ok; // Edge two may act
   assign e1_ok = active & edge_pass_enable & edge_one_hit;
   // With ordering on, edge two waits for the edge-one flag
   assign e2_ok = active & edge_pass_enable & edge_two_hit &
                  (~edge_order_enable | edge_one_flag);

   // ****************************************************
   // Register writes and the control word
   // ****************************************************
   // Address decode; writes to unmapped offsets are ignored
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   assign wr_ctrl = reg_write_in & (reg_addr_in == `CTU_ADDR_CTRL);
   assign wr_stat = reg_write_in & (reg_addr_in == `CTU_ADDR_STAT);
   assign wr_mask = reg_write_in & (reg_addr_in == `CTU_ADDR_MASK);

   // Control word; hardware edge one wins over a software clear
   // Bits outside the write mask stay zero and read back as zero.
   // Setting the edge-one flag by software starts a measurement just as
   // a hardware edge does
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         ctrl_r <= `CTU_CTRL_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= reg_wdata_in & `CTU_CTRL_WMASK;
         end
         if (e1_ok) begin
            ctrl_r[`CTU_B_EDGE1] <= 1'b1;
         end
      end
   end

   // Sticky status, write one to clear, set wins
   // A same-cycle event beats the clear so no edge is ever lost;
   // software that clears and then reads sees the new event
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         stat_r <= '0;
      end else begin
         if (wr_stat) begin
            stat_r <= stat_r & ~reg_wdata_in[`CTU_S_NBITS-1:0];
         end
         if (e1_ok) begin
            stat_r[`CTU_S_EDGE1] <= 1'b1;
         end
         if (e2_ok) begin
            stat_r[`CTU_S_EDGE2] <= 1'b1;
         end
      end
   end

   // Interrupt mask
   // Mask bits share the status layout; a set bit lets that event interrupt
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         mask_r <= '0;
      end else if (wr_mask) begin
         mask_r <= reg_wdata_in[`CTU_S_NBITS-1:0];
      end
   end

   // ****************************************************
   // Measurement phase
   // ****************************************************
   // An edge two that comes while armed is recorded and may trigger,
   // but it neither starts nor ends a current pulse
   // Losing the enable or entering a halting idle drops straight to idle
   // Current runs from edge one to edge two; software rearms by
   // clearing the edge-one flag
   always_comb begin
      phase_nxt = phase_r;
      unique case (phase_r)
         // Unit off or halted: no current
         ctu_pkg::CTU_IDLE: begin
            if (active) begin
               phase_nxt = ctu_pkg::CTU_ARMED;
            end
         end
         // Live, waiting for the edge-one flag
         ctu_pkg::CTU_ARMED: begin
            if (!active) begin
               phase_nxt = ctu_pkg::CTU_IDLE;
            end else if (edge_one_flag) begin
               phase_nxt = ctu_pkg::CTU_RUN;
            end
         end
         // Current flows until edge two or a rearm
         ctu_pkg::CTU_RUN: begin
            if (!active) begin
               phase_nxt = ctu_pkg::CTU_IDLE;
            end else if (e2_ok) begin
               phase_nxt = ctu_pkg::CTU_DONE;
            end else if (!edge_one_flag) begin
               phase_nxt = ctu_pkg::CTU_ARMED;
            end
         end
         // Span closed; hold until software rearms
         ctu_pkg::CTU_DONE: begin
            if (!active) begin
               phase_nxt = ctu_pkg::CTU_IDLE;
            end else if (!edge_one_flag) begin
               phase_nxt = ctu_pkg::CTU_ARMED;
            end
         end
      endcase
   end

   // Phase register
   // The next-state value also feeds the outputs, saving a cycle of lag
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         phase_r <= ctu_pkg::CTU_IDLE;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   // All analog-side controls are registered so the pins never glitch
   // Registered analog controls and delay pulse
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         current_on_out <= 1'b0;
         current_source_ground_out <= 1'b0;
         trigger_out <= 1'b0;
         delay_pulse_out <= 1'b0;
      end else begin
         // Current follows the next phase, one cycle after the flag sets
         current_on_out <= (phase_nxt == ctu_pkg::CTU_RUN);
         // Grounding is not gated by enable so discharge works while off
         current_source_ground_out <= current_source_ground;
         // One pulse per accepted edge two; in level mode it pulses on
         // every cycle that the chosen level holds
         trigger_out <= trigger_output_enable & active & e2_ok;
         // Delay pulse spans edge one to edge two; the comparator-two
         // source is software's duty to program
         delay_pulse_out <= delay_generation_enable &
                            (phase_nxt == ctu_pkg::CTU_RUN);
      end
   end

   // Level interrupt from unmasked sticky bits
   // It falls in the cycle after a clearing write, with no extra lag
   assign irq_out = |(stat_r & mask_r);

   // Read data, valid the cycle after the strobe; unmapped reads zero
   // Reads have no side effects; status bits clear only by a written one.
   // Zero between reads keeps the data lines quiet for OR-ed buses
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         rdata_r <= '0;
      end else if (reg_read_in) begin
         unique case (reg_addr_in)
            `CTU_ADDR_CTRL: rdata_r <= ctrl_r;
            `CTU_ADDR_STAT: rdata_r <= {{(32-`CTU_S_NBITS){1'b0}}, stat_r};
            `CTU_ADDR_MASK: rdata_r <= {{(32-`CTU_S_NBITS){1'b0}}, mask_r};
            default: rdata_r <= '0;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end
   assign reg_rdata_out = rdata_r;
endmodule

// ==== dv/ctu_edge_ctrl_props.sv ====
// Purpose: Port-level checks for the charge-time edge control block
// Assumes: One clock, synchronous active-high reset
// Notes: Shadows control and mask writes to judge the outputs
`include "ctu_defines.svh"
module ctu_edge_ctrl_props (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic idle_mode_in,
   input wire logic edge_one_in,
   input wire logic current_on_out,
   input wire logic current_source_ground_out,
   input wire logic trigger_out,
   input wire logic delay_pulse_out,
   input wire logic irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************
   // Shadow state
   // ****************************************************
   logic [31:0] sh_r; // Writable control bits as software last wrote them
   logic [1:0] mk_r; // Interrupt mask as last written
   // Shadow follows writes only; hardware-set flags are not modelled here
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         sh_r <= 32'h0000_0000;
         mk_r <= 2'b00;
      end else if (reg_write_in && reg_addr_in == `CTU_ADDR_CTRL) begin
         sh_r <= reg_wdata_in & `CTU_CTRL_WMASK;
      end else if (reg_write_in && reg_addr_in == `CTU_ADDR_MASK) begin
         mk_r <= reg_wdata_in[1:0];
      end
   end
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in);
   // ****************************************************
   // Assertions
   // ****************************************************
   AST_RD_ZERO: assert property (!$past(reg_read_in) |-> reg_rdata_out == 32'h0000_0000)
      else $error("read data outside its slot");
   AST_GND_COPY: assert property (
      sh_r[`CTU_B_GND] == $past(sh_r[`CTU_B_GND]) |-> current_source_ground_out == sh_r[`CTU_B_GND])
      else $error("ground output differs from control bit");
   AST_OFF_QUIET: assert property (
      !sh_r[`CTU_B_ON] && !current_on_out && !reg_write_in && !$past(reg_write_in)
      |=> !current_on_out) else $error("measurement started while disabled");
   AST_BLOCK_QUIET: assert property (
      !sh_r[`CTU_B_EDGE_PASS_ENABLE] && !sh_r[`CTU_B_EDGE1] && !current_on_out
      && !reg_write_in && !$past(reg_write_in)
      |=> !current_on_out) else $error("measurement started with edges blocked");
   AST_IDLE_HALT: assert property (
      (sh_r[`CTU_B_IDLE] && idle_mode_in && !reg_write_in)[*3] |=> !$rose(current_on_out))
      else $error("measurement started while halted in idle");
   AST_TRIG_GATE: assert property (
      trigger_out |-> sh_r[`CTU_B_TRIG] || $past(sh_r[`CTU_B_TRIG]))
      else $error("trigger pulse while trigger disabled");
   AST_DELAY_GATE: assert property (
      delay_pulse_out |-> sh_r[`CTU_B_DELAY_GENERATION_ENABLE] || $past(sh_r[`CTU_B_DELAY_GENERATION_ENABLE]))
      else $error("delay output while delay generation off");
   AST_SYNC_DELAY: assert property (
      $rose(current_on_out) |-> $past(edge_one_in, 3) || $past(reg_write_in)
      || $past(reg_write_in, 2) || $past(reg_write_in, 3)
      || ($past(idle_mode_in, 3) && !idle_mode_in))
      else $error("measurement began sooner than the synchroniser allows");
   AST_IRQ_MASKED: assert property (mk_r == 2'b00 |-> !irq_out)
      else $error("interrupt with all events masked");
   COV_TRIG: cover property (trigger_out);
   COV_START: cover property ($rose(current_on_out));
   COV_IRQ: cover property (irq_out);
endmodule
bind ctu_edge_ctrl ctu_edge_ctrl_props u_ctu_edge_ctrl_props (
   .clock_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
   .reg_rdata_out, .idle_mode_in, .edge_one_in, .current_on_out,
   .current_source_ground_out, .trigger_out, .delay_pulse_out, .irq_out
);

// ==== dv/ctu_src_model.sv ====
// Purpose: Event sources on the far side of the edge-two selector
// Assumes: Code picks which line carries the requested level
// Notes: Unselected lines toggle every cycle so a wrong route shows
module ctu_src_model (
   input wire logic clock_in,
   input wire logic [3:0] code_in,
   input wire logic lvl_in,
   output logic [15:0] src_out,
   output logic tgl_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tgl_r = 1'b0; // Free toggle for idle lines
   always_ff @(posedge clock_in) begin
      tgl_r <= ~tgl_r;
   end
   // Selected line holds the bench level, others never sit still
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         src_out[i] = (4'(i) == code_in) ? lvl_in : tgl_r;
      end
   end
   assign tgl_out = ~tgl_r;
endmodule

// ==== dv/ctu_edge_ctrl_bench.sv ====
// Purpose: Self-checking bench for the charge-time edge control block
// Assumes: Edge-two sources come from the source model
// Notes: Read data is judged from a queue of expected words
`include "ctu_defines.svh"
module ctu_edge_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************
   // Signals
   // ****************************************************
   logic clock_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] reg_addr_in = 8'h00;
   logic [31:0] reg_wdata_in = 32'h0000_0000;
   logic reg_write_in = 1'b0;
   logic reg_read_in = 1'b0;
   logic idle_mode_in = 1'b0;
   logic edge_one_in = 1'b0;
   logic [3:0] code = 4'h0; // Line the model treats as selected
   logic lvl = 1'b0; // Level on the selected line
   logic rd_d = 1'b0; // Read strobe one cycle late
   logic [15:0] src;
   logic tgl;
   logic [31:0] reg_rdata_out;
   logic current_on_out, current_source_ground_out, trigger_out, delay_pulse_out, irq_out;
   logic [31:0] exp_q[$]; // Expected read words, oldest first
   int fail_count = 0;
   int total_checks = 0;
   integer seed = 32'h977c_751c;
   localparam logic [31:0] BASE = 32'h0000_8900; // Enabled, edges pass, trigger on
   ctu_edge_ctrl u_ctu_edge_ctrl (
      .clock_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
      .reg_rdata_out, .idle_mode_in, .edge_one_in,
      .comparator_one_output_in(src[13]), .comparator_two_output_in(src[14]),
      .comparator_three_output_in(src[15]), .peripheral_bus_clock_in(src[12]),
      .capture_module_one_in(src[9]), .capture_module_two_in(src[10]),
      .capture_module_three_in(src[11]),
      .external_edge_pin_in({src[8:4], {6{tgl}}, src[2], src[3]}),
      .compare_module_one_in(src[1]), .first_timer_in(src[0]),
      .current_on_out, .current_source_ground_out, .trigger_out, .delay_pulse_out, .irq_out
   );
   ctu_src_model u_ctu_src_model (
      .clock_in, .code_in(code), .lvl_in(lvl), .src_out(src), .tgl_out(tgl)
   );
   initial begin
      forever #2 clock_in = ~clock_in;
   end
   // Read data stands only in the cycle after the strobe
   always @(posedge clock_in) rd_d <= reg_read_in;
   always @(negedge clock_in) begin
      if (rd_d) begin
         chk("read data", exp_q.pop_front(), reg_rdata_out);
      end
   end
   // ****************************************************
   // Tasks
   // ****************************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // A gap cycle follows each strobe so no strobe is set twice at one edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge clock_in);
      reg_write_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      reg_addr_in <= a;
      reg_read_in <= 1'b1;
      @(posedge clock_in);
      reg_read_in <= 1'b0;
      @(posedge clock_in);
   endtask
   // Watch current_on (w=0) or trigger (w=1) for up to n cycles
   task automatic wait_out(input logic w, input int n, input logic e, input string nm);
      logic h;
      h = 1'b0;
      for (int i = 0; i < n && !h; i++) begin
         @(negedge clock_in);
         h = h | ((w ? trigger_out : current_on_out) === 1'b1);
      end
      @(posedge clock_in);
      chk(nm, {31'h0000_0000, e}, {31'h0000_0000, h});
      if (e && !h) stop_test();
   endtask
   // One measurement: edge one, quiet window, edge two, status, interrupt
   task automatic run(input logic [31:0] c, input logic hi, input logic e1, input logic eo,
                      input logic et);
      logic [1:0] m;
      code <= c[21:18];
      lvl <= ~hi;
      wr(`CTU_ADDR_CTRL, c);
      wr(`CTU_ADDR_STAT, 32'h0000_0003);
      edge_one_in <= e1;
      wait_out(1'b0, 8, eo, "current_on");
      edge_one_in <= 1'b0;
      repeat (2) @(negedge clock_in);
      if (eo) chk("delay", {31'h0000_0000, c[`CTU_B_DELAY_GENERATION_ENABLE]}, {31'h0000_0000, delay_pulse_out});
      chk("ground", {31'h0000_0000, c[`CTU_B_GND]}, {31'h0000_0000, current_source_ground_out});
      @(posedge clock_in);
      wait_out(1'b1, 6, 1'b0, "early trigger");
      lvl <= hi;
      wait_out(1'b1, 8, et & c[`CTU_B_TRIG], "trigger");
      lvl <= ~hi;
      rd(`CTU_ADDR_STAT, {30'h0000_0000, et, eo});
      rd(`CTU_ADDR_CTRL, c | (32'(eo) << 24));
      m = 2'($random(seed));
      wr(`CTU_ADDR_MASK, {30'h0000_0000, m});
      rd(`CTU_ADDR_MASK, {30'h0000_0000, m});
      chk("irq", {31'h0000_0000, |(m & {et, eo})}, {31'h0000_0000, irq_out});
      wr(`CTU_ADDR_STAT, 32'h0000_0003);
      chk("irq", 32'h0000_0000, {31'h0000_0000, irq_out});
      wr(`CTU_ADDR_CTRL, 32'h0000_0000);
   endtask
   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      #40000;
      fail_count++;
      stop_test();
   end
   initial begin
      repeat (3) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      @(posedge clock_in);
      rd(`CTU_ADDR_CTRL, `CTU_CTRL_RESET);
      rd(`CTU_ADDR_STAT, 32'h0000_0000);
      wr(8'h0c, $random(seed));
      rd(8'h0c, 32'h0000_0000);
      wr(`CTU_ADDR_CTRL, 32'hffff_ffff);
      rd(`CTU_ADDR_CTRL, `CTU_CTRL_WMASK);
      chk("ground", 32'h0000_0001, {31'h0000_0000, current_source_ground_out});
      wr(`CTU_ADDR_CTRL, 32'h0000_0000);
      for (int i = 0; i < 16; i++) begin
         run(BASE | 32'h00c0_0000 | (i << 18), 1'b1, 1'b1, 1'b1, 1'b1);
      end
      run(BASE | 32'h00b8_0000, 1'b0, 1'b1, 1'b1, 1'b1);
      run(BASE | 32'h0038_0000, 1'b0, 1'b1, 1'b1, 1'b1);
      run(BASE | 32'h0078_0000, 1'b1, 1'b1, 1'b1, 1'b1);
      run(32'h00f8_9a00, 1'b1, 1'b1, 1'b1, 1'b1);
      run(32'h00f8_8100, 1'b1, 1'b1, 1'b0, 1'b0);
      run(32'h00f8_0900, 1'b1, 1'b1, 1'b0, 1'b0);
      run(32'h00f8_8d00, 1'b1, 1'b0, 1'b0, 1'b0);
      run(32'h00f8_8900, 1'b1, 1'b0, 1'b0, 1'b1);
      idle_mode_in <= 1'b1;
      run(32'h00f8_a900, 1'b1, 1'b1, 1'b0, 1'b0);
      run(32'h00f8_8900, 1'b1, 1'b1, 1'b1, 1'b1);
      stop_test();
   end
endmodule
